// >>> src/timer16_waveform_mode_ctrl.sv
// 16-bit timer with waveform mode decode and two compare outputs
// assumes a classic wishbone master and port pins muxed outside
//
// Behaviour
// - nonzero channel A output mode puts wave A on its pin, except code 1 in modes where A cannot toggle
// - nonzero channel B output mode puts wave B on its pin, except code 1 in pwm modes
// - pin driver is enabled only by the pin direction bit
// - non-pwm codes: off, toggle, clear, set on match
// - fast pwm code 2 clears on match sets at top; code 3 reversed
// - fast pwm code 1 toggles A only in mode 15; B always off
// - fast pwm match equal to top is ignored when upper bit set
// - dual slope code 2 clears rising sets falling; code 3 reversed
// - dual slope code 1 toggles A only in mode 9
// - force bit in non-pwm mode applies the configured match action
// - force sets no flag and never clears the counter
// - force bits are never stored and read as zero
// - mode is two control-b bits joined with control-a bits 1:0
// - normal mode: top ffff, immediate compare load, overflow at max
// - clear-on-match top from compare A or capture, overflow at max
// - phase correct: fixed or register top, update at top, flag bottom
// - fast pwm: fixed or register top, update and flag at top
// - phase-frequency correct: top from register, update and flag bottom
// - dual slope counts bottom to top and back, top held one tick
// - capture used as top disables the capture input
// - overflow set in the same tick as bottom compare update
`timescale 1ns/100ps
module timer16_waveform_mode_ctrl
    import timer16_pkg::*;
#(
    parameter int unsigned TICK_DIV = 1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [timer16_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // port pins, index 0 is channel A
    input wire logic [1:0] gpio_out,
    input wire logic [1:0] gpio_dir,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe,
    // capture pin
    input wire logic capture_input_pin,
    output logic capture_enabled
);
    import timer16_pkg::*;

    localparam int DIV_W = $clog2(TICK_DIV + 1);

    // ----------------------------------------
    // registers and state
    // ----------------------------------------
    logic [7:0] timer16_control_a;
    logic [7:0] timer16_control_b;
    logic [15:0] count_value;
    logic [15:0] capture_value;
    logic [15:0] cmp_buf [2];
    logic [15:0] cmp_act [2];
    logic count_down;
    logic overflow_flag;
    logic [1:0] force_pend;
    logic cap_pin_d;
    logic [DIV_W-1:0] div_cnt;

    logic tick;
    logic [3:0] wave_mode_sel;
    wave_class_t cls;
    logic [15:0] top;
    logic at_top;
    logic at_bottom;
    logic upd_at_bottom;
    logic upd_pt;
    logic ovf_evt;
    logic [1:0] match;
    logic [1:0] ignore_match;
    logic [1:0] toggle_ok;
    logic [1:0] out_mode [2];
    logic [1:0] connected;
    logic [1:0] wave;
    logic access;
    logic wr;
    logic [31:0] next_dat;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0] sel);
        merge16 = old;
        if (sel[0]) begin
            merge16[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            merge16[15:8] = dat[15:8];
        end
    endfunction

    // ----------------------------------------
    // timer clock enable
    // ----------------------------------------
    assign tick = (div_cnt == '0);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            div_cnt <= '0;
        end else if (tick) begin
            div_cnt <= DIV_W'(TICK_DIV - 1);
        end else begin
            div_cnt <= div_cnt - 1'b1;
        end
    end

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    // four-bit mode from both controls
    assign wave_mode_sel = {timer16_control_b[MODE_HI_LSB +: 2],
                            timer16_control_a[MODE_LO_LSB +: 2]};
    assign out_mode[0] = timer16_control_a[OUT_MODE_A_LSB +: 2];
    assign out_mode[1] = timer16_control_a[OUT_MODE_B_LSB +: 2];

    // reserved mode 13 behaves as plain counting
    always_comb begin
        cls = CLS_NONPWM;
        top = MAX;
        upd_at_bottom = 1'b0;
        case (wave_mode_sel)
            WM_NORMAL, WM_RESERVED: top = MAX;
            WM_CTC_CMP: top = cmp_act[0];
            WM_CTC_CAP: top = capture_value;
            WM_PC8, WM_PC9, WM_PC10, WM_PC_CAP, WM_PC_CMP: begin
                cls = CLS_DUAL;
                case (wave_mode_sel)
                    WM_PC8: top = TOP_8BIT;
                    WM_PC9: top = TOP_9BIT;
                    WM_PC10: top = TOP_10BIT;
                    WM_PC_CAP: top = capture_value;
                    default: top = cmp_act[0];
                endcase
            end
            WM_FAST8, WM_FAST9, WM_FAST10, WM_FAST_CAP, WM_FAST_CMP: begin
                cls = CLS_FAST;
                case (wave_mode_sel)
                    WM_FAST8: top = TOP_8BIT;
                    WM_FAST9: top = TOP_9BIT;
                    WM_FAST10: top = TOP_10BIT;
                    WM_FAST_CAP: top = capture_value;
                    default: top = cmp_act[0];
                endcase
            end
            WM_PFC_CAP, WM_PFC_CMP: begin
                cls = CLS_DUAL;
                upd_at_bottom = 1'b1;
                top = (wave_mode_sel == WM_PFC_CAP) ? capture_value : cmp_act[0];
            end
            default: top = MAX;
        endcase
    end

    // capture input off while it sets top
    assign capture_enabled = !(wave_mode_sel == WM_PFC_CAP || wave_mode_sel == WM_PC_CAP ||
                               wave_mode_sel == WM_CTC_CAP || wave_mode_sel == WM_FAST_CAP);

    assign at_top = tick && (count_value == top);
    assign at_bottom = tick && (count_value == BOTTOM);
    assign upd_pt = upd_at_bottom ? at_bottom : at_top;

    always_comb begin
        case (cls)
            CLS_FAST: ovf_evt = at_top;
            // bottom flag shares the update tick in phase-frequency correct modes only
            CLS_DUAL: ovf_evt = at_bottom;
            default: ovf_evt = tick && (count_value == MAX);
        endcase
    end

    // ----------------------------------------
    // bus access
    // ----------------------------------------
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = access && wb_we_i;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            timer16_control_a <= CTRL_RESET;
            timer16_control_b <= CTRL_RESET;
        end else if (wr && wb_sel_i[0]) begin
            if (wb_adr_i == ADR_CTRL_A) begin
                timer16_control_a <= wb_dat_i[7:0] &
                    ~(8'h01 << FORCE_A_BIT | 8'h01 << FORCE_B_BIT);
            end
            if (wb_adr_i == ADR_CTRL_B) begin
                timer16_control_b <= wb_dat_i[7:0] & ~(8'h01 << CTRL_B_RSVD_BIT);
            end
        end
    end

    // force acts one cycle later so the freshly written mode applies
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            force_pend <= 2'b00;
        end else if (wr && wb_sel_i[0] && wb_adr_i == ADR_CTRL_A) begin
            force_pend <= {wb_dat_i[FORCE_B_BIT], wb_dat_i[FORCE_A_BIT]};
        end else begin
            force_pend <= 2'b00;
        end
    end

    // ----------------------------------------
    // counter
    // ----------------------------------------
    // forced compares never reach the counter
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            count_value <= COUNT_RESET;
            count_down <= 1'b0;
        end else if (wr && wb_adr_i == ADR_COUNT) begin
            count_value <= merge16(count_value, wb_dat_i, wb_sel_i);
        end else if (tick) begin
            case (cls)
                // dual slope turns at top and bottom
                CLS_DUAL: begin
                    if (!count_down && count_value >= top) begin
                        count_down <= 1'b1;
                        count_value <= count_value - 16'h0001;
                    end else if (count_down && count_value == BOTTOM) begin
                        count_down <= 1'b0;
                        count_value <= count_value + 16'h0001;
                    end else begin
                        count_value <= count_down ? count_value - 16'h0001
                                                  : count_value + 16'h0001;
                    end
                end
                default: begin
                    count_down <= 1'b0;
                    count_value <= (count_value == top) ? BOTTOM : count_value + 16'h0001;
                end
            endcase
        end
    end

    // ----------------------------------------
    // overflow and capture
    // ----------------------------------------
    // a new overflow wins over a clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            overflow_flag <= 1'b0;
        end else if (ovf_evt) begin
            overflow_flag <= 1'b1;
        end else if (wr && wb_sel_i[0] && wb_adr_i == ADR_STATUS &&
                     wb_dat_i[STAT_OVF_BIT]) begin
            overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cap_pin_d <= 1'b0;
            capture_value <= COUNT_RESET;
        end else begin
            cap_pin_d <= capture_input_pin;
            if (wr && wb_adr_i == ADR_CAPTURE) begin
                capture_value <= merge16(capture_value, wb_dat_i, wb_sel_i);
            end else if (capture_enabled && capture_input_pin && !cap_pin_d) begin
                capture_value <= count_value;
            end
        end
    end

    // ----------------------------------------
    // compare channels
    // ----------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            logic [4:0] ch_adr;
            assign ch_adr = (ch == 0) ? ADR_CMP_A : ADR_CMP_B;

            // pwm writes wait in the buffer
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    cmp_buf[ch] <= COUNT_RESET;
                    cmp_act[ch] <= COUNT_RESET;
                end else begin
                    if (wr && wb_adr_i == ch_adr) begin
                        cmp_buf[ch] <= merge16(cmp_buf[ch], wb_dat_i, wb_sel_i);
                        if (cls == CLS_NONPWM) begin
                            cmp_act[ch] <= merge16(cmp_buf[ch], wb_dat_i, wb_sel_i);
                        end
                    end
                    if (cls != CLS_NONPWM && upd_pt) begin
                        cmp_act[ch] <= cmp_buf[ch];
                    end
                end
            end

            assign match[ch] = tick && (count_value == cmp_act[ch]);
            assign ignore_match[ch] = (cmp_act[ch] == top) && out_mode[ch][1];
            if (ch == 0) begin : g_tog
                assign toggle_ok[ch] = (cls == CLS_NONPWM) ||
                    (cls == CLS_FAST && wave_mode_sel == WM_FAST_CMP) ||
                    (cls == CLS_DUAL && (wave_mode_sel == WM_PFC_CMP ||
                                         wave_mode_sel == WM_FAST_CAP));
            end else begin : g_tog
                assign toggle_ok[ch] = (cls == CLS_NONPWM);
            end
            assign connected[ch] = (out_mode[ch] != 2'h0) &&
                                   !(out_mode[ch] == 2'h1 && !toggle_ok[ch]);

            wave_out_unit u_wave (
                .ref_clk(ref_clk),
                .srst(srst),
                .match(match[ch]),
                .at_top(at_top),
                .force_hit(force_pend[ch] && cls == CLS_NONPWM),
                .count_down(count_down),
                .cls(cls),
                .out_mode(out_mode[ch]),
                .toggle_ok(toggle_ok[ch]),
                .ignore_match(ignore_match[ch]),
                .wave(wave[ch])
            );

            assign pin_out[ch] = connected[ch] ? wave[ch] : gpio_out[ch];
            // direction bit alone enables the driver
            assign pin_oe[ch] = gpio_dir[ch];
        end
    endgenerate

    // ----------------------------------------
    // read data and acknowledge
    // ----------------------------------------
    always_comb begin
        next_dat = 32'h0000_0000;
        case (wb_adr_i)
            ADR_CTRL_A: next_dat[7:0] = timer16_control_a;
            ADR_CTRL_B: next_dat[7:0] = timer16_control_b;
            ADR_COUNT: next_dat[15:0] = count_value;
            ADR_CMP_A: next_dat[15:0] = cmp_buf[0];
            ADR_CMP_B: next_dat[15:0] = cmp_buf[1];
            ADR_CAPTURE: next_dat[15:0] = capture_value;
            ADR_STATUS: begin
                next_dat[STAT_OVF_BIT] = overflow_flag;
                next_dat[STAT_CAP_EN_BIT] = capture_enabled;
            end
            default: next_dat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= access;
            if (access && !wb_we_i) begin
                wb_dat_o <= next_dat;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_force_reads_zero:
    assert property (@(posedge ref_clk) disable iff (srst)
        (wb_ack_o && wb_adr_i == ADR_CTRL_A && !wb_we_i) |-> wb_dat_o[3:2] == 2'b00)
        else $error("force bits read back nonzero");

    chk_pin_shows_wave:
    assert property (@(posedge ref_clk) disable iff (srst)
        (cls == CLS_NONPWM && out_mode[0] != 2'h0) |-> pin_out[0] == wave[0])
        else $error("wave A not on its pin");

    chk_normal_max_flag:
    assert property (@(posedge ref_clk) disable iff (srst)
        (wave_mode_sel == WM_NORMAL && tick && count_value == MAX) |=> overflow_flag)
        else $error("overflow not set at max");

    chk_dual_top_turn:
    assert property (@(posedge ref_clk) disable iff (srst)
        (cls == CLS_DUAL && at_top && !count_down && !wr && top != BOTTOM)
        |=> count_down && count_value == $past(top) - 16'h0001)
        else $error("dual slope did not turn at top");

    chk_buffer_holds:
    assert property (@(posedge ref_clk) disable iff (srst)
        (cls != CLS_NONPWM && !upd_pt) |=> $stable(cmp_act[1]))
        else $error("active compare changed off the update point");

    chk_bottom_update_flag:
    assert property (@(posedge ref_clk) disable iff (srst)
        (upd_at_bottom && upd_pt) |=> overflow_flag && cmp_act[1] == $past(cmp_buf[1]))
        else $error("flag and update not together at bottom");

    chk_force_no_flag:
    assert property (@(posedge ref_clk) disable iff (srst)
        (force_pend != 2'b00 && !ovf_evt && !overflow_flag) |=> !overflow_flag)
        else $error("force set the overflow flag");

    chk_fast_top_set:
    assert property (@(posedge ref_clk) disable iff (srst)
        (cls == CLS_FAST && out_mode[1] == 2'h2 && at_top) ##1 (out_mode[1] == 2'h2)
        |-> wave[1])
        else $error("fast pwm did not set at top");

    chk_capture_off:
    assert property (@(posedge ref_clk) disable iff (srst)
        (wave_mode_sel == WM_FAST_CAP || wave_mode_sel == WM_CTC_CAP) |-> !capture_enabled)
        else $error("capture left on while setting top");

endmodule

// >>> src/timer16_pkg.sv
// constants shared by the 16-bit timer waveform control block
// assumes a 32-bit classic wishbone register bus, byte addresses
package timer16_pkg;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam int ADR_W = 5;
    localparam logic [4:0] ADR_CTRL_A = 5'h00;
    localparam logic [4:0] ADR_CTRL_B = 5'h04;
    localparam logic [4:0] ADR_COUNT = 5'h08;
    localparam logic [4:0] ADR_CMP_A = 5'h0c;
    localparam logic [4:0] ADR_CMP_B = 5'h10;
    localparam logic [4:0] ADR_CAPTURE = 5'h14;
    localparam logic [4:0] ADR_STATUS = 5'h18;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int OUT_MODE_A_LSB = 6;
    localparam int OUT_MODE_B_LSB = 4;
    localparam int FORCE_A_BIT = 3;
    localparam int FORCE_B_BIT = 2;
    localparam int MODE_LO_LSB = 0;
    localparam int MODE_HI_LSB = 3;
    localparam int CTRL_B_RSVD_BIT = 5;
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_CAP_EN_BIT = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // ----------------------------------------
    // counting limits
    // ----------------------------------------
    localparam logic [15:0] BOTTOM = 16'h0000;
    localparam logic [15:0] MAX = 16'hffff;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;

    // ----------------------------------------
    // waveform modes
    // ----------------------------------------
    localparam logic [3:0] WM_NORMAL = 4'h0;
    localparam logic [3:0] WM_PC8 = 4'h1;
    localparam logic [3:0] WM_PC9 = 4'h2;
    localparam logic [3:0] WM_PC10 = 4'h3;
    localparam logic [3:0] WM_CTC_CMP = 4'h4;
    localparam logic [3:0] WM_FAST8 = 4'h5;
    localparam logic [3:0] WM_FAST9 = 4'h6;
    localparam logic [3:0] WM_FAST10 = 4'h7;
    localparam logic [3:0] WM_PFC_CAP = 4'h8;
    localparam logic [3:0] WM_PFC_CMP = 4'h9;
    localparam logic [3:0] WM_PC_CAP = 4'ha;
    localparam logic [3:0] WM_PC_CMP = 4'hb;
    localparam logic [3:0] WM_CTC_CAP = 4'hc;
    localparam logic [3:0] WM_RESERVED = 4'hd;
    localparam logic [3:0] WM_FAST_CAP = 4'he;
    localparam logic [3:0] WM_FAST_CMP = 4'hf;

    typedef enum logic [1:0] {
        CLS_NONPWM = 2'b00,
        CLS_FAST = 2'b01,
        CLS_DUAL = 2'b10
    } wave_class_t;

endpackage

// >>> src/wave_out_unit.sv
// one compare-output channel: applies the output mode to the wave level
// assumes match, at_top and force are already qualified one-cycle pulses
`timescale 1ns/100ps
module wave_out_unit
    import timer16_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // events
    input wire logic match,
    input wire logic at_top,
    input wire logic force_hit,
    input wire logic count_down,
    // configuration
    input wire timer16_pkg::wave_class_t cls,
    input wire logic [1:0] out_mode,
    input wire logic toggle_ok,
    input wire logic ignore_match,
    // wave level
    output logic wave
);
    import timer16_pkg::*;

    logic next_wave;

    always_comb begin
        next_wave = wave;
        case (cls)
            CLS_NONPWM: begin
                if (match || force_hit) begin
                    case (out_mode)
                        2'h1: next_wave = ~wave;
                        2'h2: next_wave = 1'b0;
                        2'h3: next_wave = 1'b1;
                        default: next_wave = wave;
                    endcase
                end
            end
            CLS_FAST: begin
                if (out_mode == 2'h1) begin
                    if (match && toggle_ok) begin
                        next_wave = ~wave;
                    end
                end else if (out_mode[1]) begin
                    // match equal to top is dropped
                    if (match && !ignore_match) begin
                        next_wave = out_mode[0];
                    end
                    if (at_top) begin
                        next_wave = ~out_mode[0];
                    end
                end
            end
            CLS_DUAL: begin
                if (match) begin
                    if (out_mode == 2'h1 && toggle_ok) begin
                        next_wave = ~wave;
                    end else if (out_mode[1]) begin
                        next_wave = count_down ? ~out_mode[0] : out_mode[0];
                    end
                end
            end
            default: next_wave = wave;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wave <= 1'b0;
        end else begin
            wave <= next_wave;
        end
    end

endmodule

// >>> sim/tb_top.sv
// self-checking bench for the timer waveform control block
// assumes the block answers wishbone one cycle after it takes a request
`timescale 1ns/100ps
module tb_top;
    import timer16_pkg::*;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic ack, cap_en;
    logic [1:0] gout = 2'b01, gdir = 2'b10, pout, poe;
    logic cap_pin = 1'b0;
    int fails = 0, total_checks = 0, cycles = 0;
    timer16_waveform_mode_ctrl dut (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .gpio_out(gout), .gpio_dir(gdir), .pin_out(pout),
        .pin_oe(poe), .capture_input_pin(cap_pin), .capture_enabled(cap_en));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'h3;
        do @(posedge ref_clk); while (ack !== 1'b1 && cycles < 4000);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_force();
        logic [1:0] code [4] = '{2'h3, 2'h2, 2'h3, 2'h1};
        logic lvl [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, ADR_CTRL_A, {24'h0, code[i], 6'b001000});
            repeat (3) @(posedge ref_clk);
            check(pout[0], lvl[i]);
        end
        check(poe, gdir);
        gdir <= 2'b01;
        @(posedge ref_clk);
        check(poe, 2'b01);
        check(pout[1], gout[1]);
        bus(1'b0, ADR_CTRL_A, 32'h0);
        check(q, 32'h40);
        bus(1'b0, ADR_STATUS, 32'h0);
        check(q[0], 1'b0);
        // normal mode flags at max; the flag is then cleared for later scenarios
        bus(1'b1, ADR_COUNT, 32'hfffa);
        repeat (10) @(posedge ref_clk);
        bus(1'b0, ADR_STATUS, 32'h0);
        check(q[0], 1'b1);
        bus(1'b1, ADR_STATUS, 32'h1);
        bus(1'b0, ADR_STATUS, 32'h0);
        check(q[0], 1'b0);
    endtask
    // fast pwm 8-bit: flag must come at 0x00ff, well before 0xffff;
    // channel B is set at top and cleared again at compare 0x80
    task automatic t_fast();
        bus(1'b1, ADR_CTRL_A, 32'h21);
        bus(1'b1, ADR_CTRL_B, 32'h08);
        bus(1'b1, ADR_CMP_B, 32'h80);
        bus(1'b1, ADR_COUNT, 32'hf0);
        repeat (30) @(posedge ref_clk);
        check(pout[1], 1'b1);
        bus(1'b0, ADR_STATUS, 32'h0);
        check(q[0], 1'b1);
        bus(1'b0, ADR_COUNT, 32'h0);
        check(q[15:8], 8'h00);
        repeat (130) @(posedge ref_clk);
        check(pout[1], 1'b0);
    endtask
    // mode 8 with top 0x40: flag and compare update at bottom, channel B
    // clears at 0x20 going up and is set again at 0x20 coming down
    task automatic t_capture();
        check(cap_en, 1'b1);
        bus(1'b1, ADR_CTRL_A, 32'h20);
        bus(1'b1, ADR_CTRL_B, 32'h10);
        @(posedge ref_clk);
        check(cap_en, 1'b0);
        bus(1'b1, ADR_CAPTURE, 32'h40);
        bus(1'b1, ADR_CMP_B, 32'h20);
        bus(1'b1, ADR_STATUS, 32'h1);
        bus(1'b1, ADR_COUNT, 32'h10);
        repeat (20) @(posedge ref_clk);
        bus(1'b0, ADR_STATUS, 32'h0);
        check(q[0], 1'b1);
        repeat (40) @(posedge ref_clk);
        check(pout[1], 1'b0);
        repeat (60) @(posedge ref_clk);
        check(pout[1], 1'b1);
        cap_pin <= 1'b1;
        @(posedge ref_clk);
        cap_pin <= 1'b0;
        bus(1'b0, ADR_CAPTURE, 32'h0);
        check(q[15:0], 16'h0040);
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails++;
            final_report();
        end
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        check(pout, gout);
        t_force();
        t_fast();
        t_capture();
        final_report();
    end
endmodule
